/* src/local_switch_bank.sv */
// How it works
// - sixteen identical independent switches, each driving its own local bit output
// - a position is selectable only while its label is present
// - ON holds the bit at 1, OFF holds it at 0 until changed
// - MOMENTARY gives 1 for one processing interval, then back to 0
// - ON/OFF, OFF/MOMENTARY or ON/OFF/MOMENTARY, chosen by which labels exist
// - the name label only identifies the switch, never drives the bit
// - all labels cleared means disabled, bit fixed at 0
// - held bit states survive power loss and come back after power-up
// - bit states survive any label change that leaves the switch enabled
// - reconfiguring labels never interrupts driving of the local bits
// - a switch whose labels are cleared is forced to 0
// - a switch newly given labels starts at 0
// - bits are refreshed once per quarter-cycle processing interval
`timescale 1ns/1ps
`default_nettype none

module local_switch_bank
  import lcs_pkg::*;
#(
  parameter int PROC_CYCLES = PROC_CYCLES_DEF
)
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                nv_clear_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [NUM_SW-1:0]   local_bit
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [NUM_SW*LBL_W-1:0] label_q;
  logic [NUM_SW-1:0]       bits_q;
  logic [NUM_SW-1:0]       local_bit_reg;
  logic [NUM_SW-1:0]       pulse_reg;
  logic [NUM_SW-1:0]       pend_valid_reg;
  logic [2*NUM_SW-1:0]     pend_pos_reg;
  logic [NUM_SW-1:0]       enabled;
  logic [NUM_SW-1:0]       hold_value;
  logic [TICK_W-1:0]       count_reg;
  logic                    tick_reg;
  logic                    restore_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic [31:0]             prdata_reg;
  logic [31:0]             prdata_next;
  logic                    mapped;
  logic                    access;
  logic                    wr_label_lo;
  logic                    wr_label_hi;
  logic                    wr_command;
  logic [CMD_SW_W-1:0]     cmd_sw;
  logic [CMD_POS_W-1:0]    cmd_pos;

  assign local_bit = local_bit_reg;
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;

  // ----------------------------------------------------------------
  // processing interval divider
  // ----------------------------------------------------------------
  // tick is a one-cycle enable; nothing else in the block runs slower
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end
    else if (count_reg == TICK_W'(PROC_CYCLES - 1))
    begin
      count_reg <= '0;
      tick_reg  <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
      tick_reg  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb slave, zero wait states: answer prepared in the setup cycle
  // ----------------------------------------------------------------
  assign access      = psel && penable && pready_reg;
  assign wr_label_lo = access && pwrite && (paddr == ADDR_LABEL_LO);
  assign wr_label_hi = access && pwrite && (paddr == ADDR_LABEL_HI);
  assign wr_command  = access && pwrite && (paddr == ADDR_COMMAND);
  assign cmd_sw      = pwdata[CMD_SW_LSB +: CMD_SW_W];
  assign cmd_pos     = pwdata[CMD_POS_LSB +: CMD_POS_W];

  always_comb
  begin
    mapped      = 1'b1;
    prdata_next = READ_ZERO;
    unique case (paddr)
      ADDR_LABEL_LO: prdata_next = label_q[31:0];
      ADDR_LABEL_HI: prdata_next = label_q[63:32];
      ADDR_COMMAND:  prdata_next = READ_ZERO;
      ADDR_STATE:    prdata_next = {pend_valid_reg, local_bit_reg};
      ADDR_ENABLED:  prdata_next = {pulse_reg, enabled};
      default:       mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= READ_ZERO;
    end
    else if (psel && !penable)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !mapped;
      prdata_reg  <= (pwrite || !mapped) ? READ_ZERO : prdata_next;
    end
    else
    begin
      // cleared outside the access cycle so a stale word is never read
      // as a fresh answer
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // power-up restore of held positions
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      restore_reg <= 1'b1;
    else
      restore_reg <= 1'b0;
  end

  // labels live in the retained store so a power cycle keeps the types;
  // a momentary pulse is never stored, only the held ON or OFF value
  retained_store u_store (
    .pclk        (pclk),
    .nv_clear_n  (nv_clear_n),
    .label_we    ({wr_label_hi, wr_label_lo}),
    .label_wdata (pwdata),
    .bits_we     (!restore_reg),
    .bits_wdata  (hold_value),
    .label_q     (label_q),
    .bits_q      (bits_q)
  );

  // ----------------------------------------------------------------
  // per-switch logic
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_SW; i++)
    begin : g_sw
      logic [LBL_W-1:0] lbl;
      logic             on_ok;
      logic             off_ok;
      logic             mom_ok;
      logic [1:0]       req;

      assign lbl    = label_q[i*LBL_W +: LBL_W];
      assign enabled[i] = |lbl;
      assign on_ok  = lbl[LBL_SET];
      assign off_ok = lbl[LBL_CLEAR];
      assign mom_ok = lbl[LBL_PULSE];
      assign req    = pend_valid_reg[i] ? pend_pos_reg[2*i +: 2] : POS_NONE;
      assign hold_value[i] = local_bit_reg[i] && !pulse_reg[i];

      // a request made in the tick cycle is kept for the next interval
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pend_valid_reg[i]     <= 1'b0;
          pend_pos_reg[2*i +: 2] <= POS_NONE;
        end
        else if (wr_command && cmd_sw == CMD_SW_W'(i)
                 && cmd_pos != POS_NONE)
        begin
          pend_valid_reg[i]     <= 1'b1;
          pend_pos_reg[2*i +: 2] <= cmd_pos;
        end
        else if (tick_reg)
          pend_valid_reg[i] <= 1'b0;
      end

      // disable forcing does not wait for a tick, so a cleared switch drops
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          local_bit_reg[i] <= 1'b0;
        else if (restore_reg)
          local_bit_reg[i] <= bits_q[i] && enabled[i];
        else if (!enabled[i])
          local_bit_reg[i] <= 1'b0;
        else if (tick_reg)
        begin
          if (req == POS_ON && on_ok)
            local_bit_reg[i] <= 1'b1;
          else if (req == POS_OFF && off_ok)
            local_bit_reg[i] <= 1'b0;
          else if (req == POS_MOM && mom_ok)
            local_bit_reg[i] <= 1'b1;
          else if (pulse_reg[i])
            local_bit_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pulse_reg[i] <= 1'b0;
        else if (!enabled[i] || restore_reg)
          pulse_reg[i] <= 1'b0;
        else if (tick_reg)
          pulse_reg[i] <= (req == POS_MOM) && mom_ok;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [NUM_SW-1:0] enabled_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enabled_d <= '0;
    else
      enabled_d <= enabled;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_mom_req;
    tick_reg && !restore_reg && enabled[0] && pend_valid_reg[0]
      && pend_pos_reg[1:0] == POS_MOM && label_q[LBL_PULSE];
  endsequence

  sequence s_pulse_end;
    tick_reg && pulse_reg[0] && enabled[0] && !pend_valid_reg[0];
  endsequence

  chk_disabled_zero: assert property (
    ((local_bit_reg & ~enabled_d) == '0) || $past(restore_reg))
    else $error("disabled switch drives a one");

  chk_mom_start: assert property (
    s_mom_req ##1 enabled[0] |-> local_bit_reg[0] && pulse_reg[0])
    else $error("momentary request did not pulse the bit");

  chk_mom_end: assert property (
    s_pulse_end ##1 enabled[0] |-> !local_bit_reg[0] && !pulse_reg[0])
    else $error("momentary pulse outlasted one interval");

  chk_tick_only: assert property (
    !$past(tick_reg) && !$past(restore_reg)
      && ($past(enabled) == $past(enabled, 2))
      |-> $stable(local_bit_reg))
    else $error("local bit moved between intervals");

  chk_on_sets: assert property (
    tick_reg && !restore_reg && pend_valid_reg[0]
      && pend_pos_reg[1:0] == POS_ON && label_q[LBL_SET]
      ##1 enabled[0] |-> local_bit_reg[0])
    else $error("on request did not set the bit");

  chk_off_clears: assert property (
    tick_reg && !restore_reg && pend_valid_reg[0]
      && pend_pos_reg[1:0] == POS_OFF && label_q[LBL_CLEAR]
      |=> !local_bit_reg[0])
    else $error("off request did not clear the bit");

  chk_absent_ignored: assert property (
    tick_reg && !restore_reg && !pulse_reg[0] && pend_valid_reg[0]
      && pend_pos_reg[1:0] == POS_ON && !label_q[LBL_SET]
      ##1 enabled[0] |-> $stable(local_bit_reg[0]))
    else $error("unlabelled position changed the bit");

  chk_store_tracks: assert property (
    !restore_reg |=> bits_q == $past(hold_value))
    else $error("retained store lags the held state");

  // the release edge still runs the reset branch, so the load is judged
  // only from an edge at which presetn already reads high
  chk_restore_load: assert property (
    presetn && restore_reg
      |=> local_bit_reg == ($past(bits_q) & $past(enabled)))
    else $error("power-up restore lost the held state");

  // a tick in the cycle after the write may move a bit on its own
  chk_label_keep: assert property (
    (wr_label_lo || wr_label_hi) && !tick_reg && !restore_reg
      ##1 (enabled == $past(enabled)) && !tick_reg
      |=> $stable(local_bit_reg))
    else $error("settings write disturbed an enabled bit");

  chk_apb_answer: assert property (
    psel && !penable |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not exactly one access cycle");

  chk_new_zero: assert property (
    (local_bit_reg & enabled & ~$past(enabled)) == '0)
    else $error("newly enabled switch did not start at zero");

  chk_pulse_high: assert property (
    (pulse_reg & ~local_bit_reg) == '0)
    else $error("pulse flag set while the bit is low");

  chk_pend_clear: assert property (
    tick_reg && !wr_command |=> pend_valid_reg == '0)
    else $error("request outlived its interval");

  chk_apb_refuse: assert property (
    psel && !penable && !mapped
      |=> pready_reg && pslverr_reg && prdata_reg == READ_ZERO)
    else $error("unmapped address not refused");

  chk_bus_idle: assert property (
    !pready_reg |-> !pslverr_reg && prdata_reg == READ_ZERO)
    else $error("bus answer outside the access cycle");

endmodule

`default_nettype wire

/* src/lcs_pkg.sv */
package lcs_pkg;

  // ----------------------------------------------------------------
  // switch bank shape and label layout
  // ----------------------------------------------------------------
  localparam int NUM_SW    = 16;
  localparam int LBL_W     = 4;
  localparam int LBL_NAME  = 0;
  localparam int LBL_CLEAR = 1;
  localparam int LBL_SET   = 2;
  localparam int LBL_PULSE = 3;
  localparam int SW_PER_WORD = 8;

  // ----------------------------------------------------------------
  // position request codes
  // ----------------------------------------------------------------
  localparam logic [1:0] POS_NONE = 2'h0;
  localparam logic [1:0] POS_ON   = 2'h1;
  localparam logic [1:0] POS_OFF  = 2'h2;
  localparam logic [1:0] POS_MOM  = 2'h3;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_LABEL_LO = 8'h00;
  localparam logic [7:0] ADDR_LABEL_HI = 8'h04;
  localparam logic [7:0] ADDR_COMMAND  = 8'h08;
  localparam logic [7:0] ADDR_STATE    = 8'h0C;
  localparam logic [7:0] ADDR_ENABLED  = 8'h10;
  localparam int CMD_SW_LSB  = 0;
  localparam int CMD_SW_W    = 4;
  localparam int CMD_POS_LSB = 4;
  localparam int CMD_POS_W   = 2;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // processing interval: a quarter of one power-system cycle
  // ----------------------------------------------------------------
  localparam int PCLK_HZ       = 40_000_000;
  localparam int LINE_HZ       = 60;
  localparam int INTERVAL_DIV  = 4;
  localparam int PROC_CYCLES_DEF = PCLK_HZ / (LINE_HZ * INTERVAL_DIV);
  localparam int TICK_W        = 18;

endpackage

/* src/retained_store.sv */
`timescale 1ns/1ps
`default_nettype none

// battery-backed storage: presetn does not reach it, only nv_clear_n
module retained_store
  import lcs_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     nv_clear_n,
  input  wire logic [1:0]               label_we,
  input  wire logic [31:0]              label_wdata,
  input  wire logic                     bits_we,
  input  wire logic [NUM_SW-1:0]        bits_wdata,
  output logic      [NUM_SW*LBL_W-1:0]  label_q,
  output logic      [NUM_SW-1:0]        bits_q
);

  genvar w;
  generate
    for (w = 0; w < 2; w++)
    begin : g_word
      always_ff @(posedge pclk or negedge nv_clear_n)
      begin
        if (!nv_clear_n)
          label_q[w*32 +: 32] <= READ_ZERO;
        else if (label_we[w])
          label_q[w*32 +: 32] <= label_wdata;
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge nv_clear_n)
  begin
    if (!nv_clear_n)
      bits_q <= '0;
    else if (bits_we)
      bits_q <= bits_wdata;
  end

endmodule

`default_nettype wire

/* bench/panel_operator.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// operator panel: turns bench requests into apb transfers
// ----------------------------------------------------------------
module panel_operator
  import lcs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              req,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              pready,
  input  wire logic [31:0]       prdata,
  input  wire logic              pslverr,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [31:0]       pwdata,
  output logic                   done,
  output logic      [31:0]       rdata,
  output logic                   err
);
  logic [1:0] st;

  // the panel is the only path that issues position commands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st      <= 2'h0;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 8'h00;
      pwdata  <= 32'h0000_0000;
      done    <= 1'b0;
      rdata   <= 32'h0000_0000;
      err     <= 1'b0;
    end
    else
    begin
      case (st)
        2'h0:
          if (req)
          begin
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= addr;
            pwdata <= wdata;
            st     <= 2'h1;
          end
        2'h1:
        begin
          penable <= 1'b1;
          st      <= 2'h2;
        end
        2'h2:
          if (pready)
          begin
            rdata   <= prdata;
            err     <= pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            // released lines show garbage, not the last value
            paddr   <= ~paddr;
            pwdata  <= ~pwdata;
            done    <= 1'b1;
            st      <= 2'h3;
          end
        default:
          if (!req)
          begin
            done <= 1'b0;
            st   <= 2'h0;
          end
      endcase
    end
  end
endmodule

`default_nettype wire

/* bench/local_switch_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module local_switch_bank_tb;
  import lcs_pkg::*;
  localparam int PC = 8;
  logic              pclk, presetn, nv_clear_n, req, wr, done, err;
  logic              psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] addr, paddr;
  logic [31:0]       wdata, pwdata, prdata, rdata, rd;
  logic [NUM_SW-1:0] local_bit, mb;
  logic [3:0]        lbl [NUM_SW];
  logic [1:0]        p;
  int                bad_count, comparisons, cycles, seed, i, n, k;

  local_switch_bank #(.PROC_CYCLES(PC)) dut (.pclk(pclk),
    .presetn(presetn), .nv_clear_n(nv_clear_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .local_bit(local_bit));
  panel_operator u_panel (.pclk(pclk), .presetn(presetn), .req(req),
    .wr(wr), .addr(addr), .wdata(wdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done),
    .rdata(rdata), .err(err));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // limit sized for ~1500 cycles of traffic
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req   <= 1'b1;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge pclk);
    while (done !== 1'b1)
      @(posedge pclk);
    req <= 1'b0;
    rd = rdata;
  endtask

  task cmd(input int s, input logic [1:0] pos);
    apb(1'b1, ADDR_COMMAND, {26'h0, pos, s[3:0]});
  endtask

  function automatic logic [31:0] lword(input int h);
    for (int j = 0; j < SW_PER_WORD; j++)
      lword[4*j +: 4] = lbl[SW_PER_WORD*h + j];
  endfunction

  function automatic logic [31:0] en_word();
    en_word = 32'h0000_0000;
    for (int j = 0; j < NUM_SW; j++)
      en_word[j] = |lbl[j];
  endfunction

  // expected held level once any pulse has ended
  function automatic logic next_bit(input logic c, input logic [3:0] l,
                                    input logic [1:0] q);
    if (l == 4'h0)
      next_bit = 1'b0;
    else if (q == POS_ON && l[LBL_SET])
      next_bit = 1'b1;
    else if (q == POS_OFF && l[LBL_CLEAR])
      next_bit = 1'b0;
    else if (q == POS_MOM && l[LBL_PULSE])
      next_bit = 1'b0;
    else
      next_bit = c;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 46;
    presetn = 1'b0;
    nv_clear_n = 1'b0;
    {req, wr, addr, wdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    nv_clear_n <= 1'b1;
    check("local_bit after wipe", 32'h0, local_bit);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped err", 32'h1, err);
    check("unmapped data", 32'h0, rd);
    apb(1'b0, ADDR_COMMAND, 32'h0);
    check("command read", 32'h0, rd);
    for (i = 0; i < NUM_SW; i++)
      lbl[i] = $random(seed);
    lbl[0] = 4'h7; lbl[1] = 4'hB; lbl[2] = 4'hF;
    lbl[3] = 4'h1; lbl[4] = 4'h0;
    apb(1'b1, ADDR_LABEL_LO, lword(0));
    apb(1'b1, ADDR_LABEL_HI, lword(1));
    apb(1'b0, ADDR_LABEL_LO, 32'h0);
    check("label lo", lword(0), rd);
    apb(1'b0, ADDR_LABEL_HI, 32'h0);
    check("label hi", lword(1), rd);
    apb(1'b0, ADDR_ENABLED, 32'h0);
    check("enabled", en_word(), rd);
    mb = '0;
    // corners first: ON, name-only, disabled, missing set, missing pulse
    for (n = 0; n < 40; n++)
    begin
      case (n)
        0: begin i = 0; p = POS_ON; end
        1: begin i = 3; p = POS_ON; end
        2: begin i = 4; p = POS_ON; end
        3: begin i = 1; p = POS_ON; end
        4: begin i = 0; p = POS_MOM; end
        default: begin i = $random(seed) & 15; p = $random(seed); end
      endcase
      cmd(i, p);
      mb[i] = next_bit(mb[i], lbl[i], p);
      repeat (2*PC+3) @(posedge pclk);
      check("local_bit", mb, local_bit);
      apb(1'b0, ADDR_STATE, 32'h0);
      check("state", {16'h0, mb}, rd);
    end
    // switch 0 as a full type, then with its set label taken away
    lbl[0] = 4'hF;
    apb(1'b1, ADDR_LABEL_LO, lword(0));
    cmd(0, POS_OFF);
    repeat (2*PC+3) @(posedge pclk);
    cmd(0, POS_MOM);
    repeat (2*PC+3) @(posedge pclk);
    lbl[0] = 4'hB;
    apb(1'b1, ADDR_LABEL_LO, lword(0));
    cmd(0, POS_ON);
    repeat (2*PC+3) @(posedge pclk);
    mb[0] = 1'b0;
    check("switch 0 after pulse", mb, local_bit);
    cmd(2, POS_OFF);
    repeat (2*PC+3) @(posedge pclk);
    cmd(2, POS_MOM);
    k = 0;
    repeat (3*PC)
    begin
      #1;
      if (local_bit[2] === 1'b1)
        k++;
      @(posedge pclk);
    end
    check("pulse width", PC, k);
    cmd(2, POS_ON);
    repeat (2*PC+3) @(posedge pclk);
    mb[2] = 1'b1;
    apb(1'b1, ADDR_LABEL_HI, lword(1));
    check("bits over relabel", mb, local_bit);
    lbl[2] = 4'h0;
    apb(1'b1, ADDR_LABEL_LO, lword(0));
    repeat (2) @(posedge pclk);
    mb[2] = 1'b0;
    check("cleared switch", mb, local_bit);
    lbl[2] = 4'hF;
    apb(1'b1, ADDR_LABEL_LO, lword(0));
    repeat (2*PC+3) @(posedge pclk);
    check("new switch", mb, local_bit);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("bits in outage", 32'h0, local_bit);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("bits restored", mb, local_bit);
    test_done();
  end
endmodule

`default_nettype wire
